// ### shared/qpr_pkg.sv
`default_nettype none
package qpr_pkg;
  // Structure sizes.
  localparam int NUM_SI = 5;
  localparam int QW = 4;
  localparam int SRC_W = 3;
  localparam int MEAS_W = 12;
  localparam int INTEG_W = 16;
  localparam int OT_W = 6;
  localparam int CNT_W = 7;
  localparam int CRED_W = 20;
  localparam int NREG = 5;

  // Address decode: byte address = si*0x40 + ch*0x20 + index*4.
  localparam int SI_LSB = 6;
  localparam int CH_BIT = 5;
  localparam int IDX_LSB = 2;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_QOS = 3'h1;
  localparam logic [2:0] IDX_TARGET = 3'h2;
  localparam logic [2:0] IDX_SCALE = 3'h3;
  localparam logic [2:0] IDX_OT = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;

  // Field positions.
  localparam int CTRL_REG_EN = 0;
  localparam int CTRL_BW_MODE = 1;
  localparam int CTRL_IDLE_RISE = 2;
  localparam int CTRL_OT_EN = 3;
  localparam int QOS_OVR_LSB = 0;
  localparam int QOS_MIN_LSB = 8;
  localparam int QOS_MAX_LSB = 12;
  localparam int OT_INT_LSB = 0;
  localparam int OT_FRAC_LSB = 8;

  // Reset value and writable bits of each register.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] MASK_CTRL = 32'h0000_000F;
  localparam logic [31:0] MASK_QOS = 32'h0000_FF0F;
  localparam logic [31:0] MASK_TARGET = 32'h0000_0FFF;
  localparam logic [31:0] MASK_SCALE = 32'h0000_00FF;
  localparam logic [31:0] MASK_OT = 32'h0000_FF3F;

  // Integrator and credit limits.
  localparam logic [11:0] INTEG_ONES = 12'hFFF;
  localparam logic signed [CRED_W-1:0] CRED_MAX = 20'h0_0100;
  localparam logic signed [CRED_W-1:0] CRED_FLOOR = 20'hC_0000;

  typedef struct packed {
    logic valid;
    logic dataless;
    logic [QW-1:0] qos;
  } qpr_req_type;

  typedef struct packed {
    logic rd;
    logic rd_zero;
    logic wr;
    logic wr_zero;
  } qpr_done_type;

  typedef struct packed {
    logic valid;
    logic [QW-1:0] qos;
    logic [QW-1:0] arb;
    logic [SRC_W-1:0] src;
  } qpr_mreq_type;
endpackage
`default_nettype wire

// ### verilog/qpr_regulator.sv
`default_nettype none
module qpr_regulator #(
  parameter int RQ_DEPTH = 16,
  parameter int RQ_RES_HIGH = 2,
  parameter int RQ_RES_MED = 2,
  parameter logic [3:0] R_THRESHOLD_UPPER = 4'hC,
  parameter logic [3:0] R_THRESHOLD_LOWER = 4'h8,
  parameter logic [qpr_pkg::NUM_SI-1:0] ACE_LITE_MASK = 5'h1C
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [qpr_pkg::NUM_SI-1:0] qos_replace_enable_inputs,
  input wire qpr_pkg::qpr_req_type [qpr_pkg::NUM_SI-1:0] ar_req,
  input wire logic [qpr_pkg::NUM_SI-1:0][3:0] read_arb_priority_promote,
  output logic [qpr_pkg::NUM_SI-1:0] ar_ready,
  input wire qpr_pkg::qpr_req_type [qpr_pkg::NUM_SI-1:0] aw_req,
  output logic [qpr_pkg::NUM_SI-1:0] aw_ready,
  input wire qpr_pkg::qpr_done_type [qpr_pkg::NUM_SI-1:0] done,
  output qpr_pkg::qpr_mreq_type m_ar,
  input wire logic m_ar_ready,
  output qpr_pkg::qpr_mreq_type m_aw,
  input wire logic m_aw_ready,
  input wire logic rq_pop
);
  localparam int N = qpr_pkg::NUM_SI;

  qpr_pkg::qpr_req_type req [2][N];
  logic [31:0] cfg_reg [2][N][qpr_pkg::NREG];
  logic [3:0] eff_qos [2][N];
  logic [3:0] reg_qos [2][N];
  logic [qpr_pkg::CNT_W-1:0] ot_cnt [N];
  logic [N-1:0] ot_ok [2];
  logic [N-1:0] hs [2];
  qpr_pkg::qpr_mreq_type mout [2];
  logic [7:0] rq_cnt_reg;
  int rq_free;
  logic [2:0] a_si;
  logic [2:0] a_idx;
  logic a_ch;
  logic a_ok;
  logic wr_en;
  logic [31:0] rd_val;
  logic [31:0] wmask;

  // Both address channels are handled by one set of per-channel logic.
  always_comb begin
    for (int s = 0; s < N; s++) begin
      req[0][s] = ar_req[s];
      req[1][s] = aw_req[s];
    end
  end

  assign ar_ready = hs[0];
  assign aw_ready = hs[1];
  assign m_ar = mout[0];
  assign m_aw = mout[1];

  // APB decode; the write OT slot exists only in the read block.
  assign a_si = paddr[qpr_pkg::SI_LSB+2:qpr_pkg::SI_LSB];
  assign a_ch = paddr[qpr_pkg::CH_BIT];
  assign a_idx = paddr[qpr_pkg::IDX_LSB+2:qpr_pkg::IDX_LSB];
  assign a_ok = (paddr[11:9] == 3'h0) && (a_si < 3'(N))
    && (a_idx <= qpr_pkg::IDX_STATUS)
    && !(a_ch && a_idx == qpr_pkg::IDX_OT);
  assign wr_en = psel && penable && pwrite && a_ok
    && (a_idx != qpr_pkg::IDX_STATUS);
  assign pready = 1'b1;

  // Read value and writable-bit mask of the addressed register.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (a_idx)
      qpr_pkg::IDX_CTRL: wmask = qpr_pkg::MASK_CTRL;
      qpr_pkg::IDX_QOS: wmask = qpr_pkg::MASK_QOS;
      qpr_pkg::IDX_TARGET: wmask = qpr_pkg::MASK_TARGET;
      qpr_pkg::IDX_SCALE: wmask = qpr_pkg::MASK_SCALE;
      qpr_pkg::IDX_OT: wmask = qpr_pkg::MASK_OT;
      default: wmask = 32'h0000_0000;
    endcase
    if (a_ok) begin
      if (a_idx == qpr_pkg::IDX_STATUS) begin
        rd_val = {17'h0_0000, ot_cnt[a_si], 4'h0, reg_qos[a_ch][a_si]};
      end else begin
        rd_val = cfg_reg[a_ch][a_si][a_idx];
      end
    end
  end

  // Read data and error are registered in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= !a_ok;
    end
  end

  // Configuration writes take effect in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++)
        for (int s = 0; s < N; s++)
          for (int r = 0; r < qpr_pkg::NREG; r++)
            cfg_reg[c][s][r] <= qpr_pkg::RST_WORD;
    end else if (wr_en) begin
      cfg_reg[a_ch][a_si][a_idx] <= pwdata & wmask;
    end
  end

  // Read queue occupancy on the master side.
  assign rq_free = RQ_DEPTH - int'(rq_cnt_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_cnt_reg <= 8'h00;
    end else begin
      rq_cnt_reg <= rq_cnt_reg + 8'(|hs[0]) - 8'(rq_pop);
    end
  end

  // Outstanding-transaction limiter, one per slave interface.
  for (genvar s = 0; s < N; s++) begin : g_ot
    logic [31:0] otc;
    logic [qpr_pkg::OT_W-1:0] it;
    logic [7:0] fr;
    logic [qpr_pkg::CNT_W-1:0] cnt_reg;
    logic [qpr_pkg::CNT_W-1:0] cap;
    logic signed [qpr_pkg::CRED_W-1:0] cred_reg;
    logic signed [qpr_pkg::CRED_W-1:0] cred_sum;
    logic lim, zr, zw, cr, cw, ok;
    assign otc = cfg_reg[0][s][qpr_pkg::IDX_OT];
    assign it = otc[qpr_pkg::OT_INT_LSB +: qpr_pkg::OT_W];
    assign fr = otc[qpr_pkg::OT_FRAC_LSB +: 8];
    assign lim = ACE_LITE_MASK[s]
      && cfg_reg[0][s][qpr_pkg::IDX_CTRL][qpr_pkg::CTRL_OT_EN];
    // Only zero-QoS requests that move data are counted.
    assign zr = req[0][s].valid && !req[0][s].dataless
      && req[0][s].qos == 4'h0;
    assign zw = req[1][s].valid && !req[1][s].dataless
      && req[1][s].qos == 4'h0;
    assign cr = hs[0][s] && zr;
    assign cw = hs[1][s] && zw;
    assign cap = qpr_pkg::CNT_W'(it) + qpr_pkg::CNT_W'(fr != 8'h00);
    assign cred_sum = cred_reg + qpr_pkg::CRED_W'({it, fr})
      - qpr_pkg::CRED_W'({cnt_reg, 8'h00});
    // Hard cap, then credit gate for the last fractional slot.
    assign ok = cnt_reg < cap
      && (cnt_reg < qpr_pkg::CNT_W'(it) || cred_reg >= 0);
    assign ot_ok[0][s] = !lim || !zr || ok;
    assign ot_ok[1][s] = !lim || !zw || (ok && !zr); // Reads go first.
    assign ot_cnt[s] = cnt_reg;

    // Count lives from handshake until read data or write response.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + qpr_pkg::CNT_W'(cr) + qpr_pkg::CNT_W'(cw)
          - qpr_pkg::CNT_W'(done[s].rd && done[s].rd_zero)
          - qpr_pkg::CNT_W'(done[s].wr && done[s].wr_zero);
      end
    end

    // Credit tracks limit minus load, saturating both ways.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cred_reg <= qpr_pkg::CRED_MAX;
      end else if (cred_sum > qpr_pkg::CRED_MAX) begin
        cred_reg <= qpr_pkg::CRED_MAX;
      end else if (cred_sum < qpr_pkg::CRED_FLOOR) begin
        cred_reg <= qpr_pkg::CRED_FLOOR;
      end else begin
        cred_reg <= cred_sum;
      end
    end

    AST_OT_INTEGER: assert property (@(posedge pclk) disable iff (!presetn)
      (lim && fr == 8'h00 && cnt_reg <= qpr_pkg::CNT_W'(it)) ##1
      $stable(otc) |-> cnt_reg <= qpr_pkg::CNT_W'(it))
      else $error("Outstanding count passed the integer limit.");
    AST_OT_PLUS_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      (lim && fr != 8'h00 && cnt_reg <= cap) ##1 $stable(otc)
      |-> cnt_reg <= cap)
      else $error("Outstanding count passed the integer limit plus one.");
  end

  // Per-channel regulators, arbiter and master-side holding register.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [N-1:0] elig;
    logic [N-1:0] win;
    logic [3:0] pr [N];
    logic [N-1:0] lrg_reg [N];
    logic [3:0] best;
    logic load;
    logic beaten;
    logic tie_lost;
    qpr_pkg::qpr_mreq_type mo_reg;

    assign load = !mo_reg.valid || (c == 0 ? m_ar_ready : m_aw_ready);
    assign hs[c] = win & {N{load}};
    assign mout[c] = mo_reg;

    for (genvar s = 0; s < N; s++) begin : g_si
      logic [31:0] ctl;
      logic [3:0] vovr, vmin, vmax, rq;
      logic [qpr_pkg::INTEG_W-1:0] integ_reg, hi, lo, step;
      logic [qpr_pkg::MEAS_W-1:0] meas_reg, target;
      logic track_reg, counted, fin, up, dn, rep, cls_ok;
      assign ctl = cfg_reg[c][s][qpr_pkg::IDX_CTRL];
      assign vovr = cfg_reg[c][s][qpr_pkg::IDX_QOS][qpr_pkg::QOS_OVR_LSB +: 4];
      assign vmin = cfg_reg[c][s][qpr_pkg::IDX_QOS][qpr_pkg::QOS_MIN_LSB +: 4];
      assign vmax = cfg_reg[c][s][qpr_pkg::IDX_QOS][qpr_pkg::QOS_MAX_LSB +: 4];
      assign target = cfg_reg[c][s][qpr_pkg::IDX_TARGET][11:0];
      assign step = 16'(cfg_reg[c][s][qpr_pkg::IDX_SCALE][7:0]);
      assign hi = {vmax, qpr_pkg::INTEG_ONES};
      assign lo = {vmin, 12'h000};
      assign counted = hs[c][s] && !req[c][s].dataless
        && req[c][s].qos == 4'h0;
      assign fin = (c == 0) ? done[s].rd && done[s].rd_zero
        : done[s].wr && done[s].wr_zero;

      // Regulated value clamped into the programmed range.
      always_comb begin
        rq = integ_reg[15:12];
        if (rq < vmin) rq = vmin;
        if (rq > vmax) rq = vmax;
      end
      assign reg_qos[c][s] = rq;

      // Replace only zero, data-moving requests on enabled interfaces.
      assign rep = qos_replace_enable_inputs[s] && req[c][s].qos == 4'h0
        && !req[c][s].dataless;
      assign eff_qos[c][s] = !rep ? req[c][s].qos
        : (ctl[qpr_pkg::CTRL_REG_EN] ? rq : vovr);
      assign pr[s] = (c == 0) ? read_arb_priority_promote[s]
        : eff_qos[c][s];

      // Read class check keeps reserved queue slots free.
      always_comb begin
        cls_ok = 1'b1;
        if (c == 0) begin
          if (eff_qos[c][s] >= R_THRESHOLD_UPPER) begin
            cls_ok = rq_free > 0;
          end else if (eff_qos[c][s] >= R_THRESHOLD_LOWER) begin
            cls_ok = rq_free > RQ_RES_HIGH;
          end else begin
            cls_ok = rq_free > RQ_RES_HIGH + RQ_RES_MED;
          end
        end
      end
      assign elig[s] = req[c][s].valid && ot_ok[c][s] && cls_ok;

      // Direction of the integrator for this cycle.
      always_comb begin
        up = 1'b0;
        dn = 1'b0;
        if (ctl[qpr_pkg::CTRL_BW_MODE]) begin
          if (counted) begin
            up = meas_reg > target;
            dn = meas_reg < target;
          end else if (!req[c][s].valid && ctl[qpr_pkg::CTRL_IDLE_RISE]) begin
            up = 1'b1;
          end
        end else if (fin && track_reg) begin
          up = meas_reg > target;
          dn = meas_reg < target;
        end
      end

      // Integrator moves by the scale step, within the range.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          integ_reg <= '0;
        end else if (ctl[qpr_pkg::CTRL_REG_EN] && up) begin
          integ_reg <= (integ_reg >= hi || hi - integ_reg <= step) ? hi
            : integ_reg + step;
        end else if (ctl[qpr_pkg::CTRL_REG_EN] && dn) begin
          integ_reg <= (integ_reg <= lo || integ_reg - lo <= step) ? lo
            : integ_reg - step;
        end
      end

      // Measurement: handshake period, or latency of one tracked request.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meas_reg <= '0;
          track_reg <= 1'b0;
        end else if (ctl[qpr_pkg::CTRL_BW_MODE]) begin
          track_reg <= 1'b0;
          if (counted) begin
            meas_reg <= '0;
          end else if ((req[c][s].valid || ctl[qpr_pkg::CTRL_IDLE_RISE])
                       && meas_reg != '1) begin
            meas_reg <= meas_reg + 1'b1;
          end
        end else if (track_reg && fin) begin
          track_reg <= 1'b0;
        end else if (!track_reg && counted) begin
          track_reg <= 1'b1;
          meas_reg <= '0;
        end else if (track_reg && meas_reg != '1) begin
          meas_reg <= meas_reg + 1'b1;
        end
      end

      AST_QOS_CARRIED: assert property (@(posedge pclk) disable iff (!presetn)
        hs[c][s] |=> mout[c].valid && mout[c].qos == $past(eff_qos[c][s])
        && mout[c].src == qpr_pkg::SRC_W'(s))
        else $error("Granted QoS not carried to the master side.");
      AST_NONZERO_PASS: assert property (@(posedge pclk)
        disable iff (!presetn)
        hs[c][s] && (req[c][s].qos != 4'h0 || req[c][s].dataless
        || !qos_replace_enable_inputs[s])
        |=> mout[c].qos == $past(req[c][s].qos))
        else $error("Unreplaceable QoS value was changed.");
      AST_MAX_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        vmax == 4'h0 |-> reg_qos[c][s] == 4'h0)
        else $error("Regulator output above a zero maximum.");
      AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        ctl[qpr_pkg::CTRL_BW_MODE] && !ctl[qpr_pkg::CTRL_IDLE_RISE]
        && !req[c][s].valid |=> $stable(integ_reg))
        else $error("Normal bandwidth regulator moved while idle.");
      AST_IDLE_RISE: assert property (@(posedge pclk) disable iff (!presetn)
        ctl[qpr_pkg::CTRL_REG_EN] && ctl[qpr_pkg::CTRL_BW_MODE]
        && ctl[qpr_pkg::CTRL_IDLE_RISE] && !req[c][s].valid
        && integ_reg < hi && step != '0 |=> integ_reg > $past(integ_reg))
        else $error("Idle-rise regulator did not climb while idle.");
      if (c == 0) begin : g_rd
        AST_ARB_CAPTURE: assert property (@(posedge pclk)
          disable iff (!presetn)
          hs[0][s] |=> m_ar.arb == $past(read_arb_priority_promote[s]))
          else $error("Read priority not captured at handshake.");
        AST_LOW_RESERVE: assert property (@(posedge pclk)
          disable iff (!presetn)
          hs[0][s] && eff_qos[0][s] < R_THRESHOLD_LOWER
          |-> rq_free > RQ_RES_HIGH + RQ_RES_MED)
          else $error("Low class read took a reserved slot.");
      end
    end

    // Largest value wins; ties resolved by grant age.
    always_comb begin
      best = 4'h0;
      win = '0;
      for (int s = 0; s < N; s++)
        if (elig[s] && pr[s] > best) best = pr[s];
      for (int s = 0; s < N; s++) begin
        win[s] = elig[s] && pr[s] == best;
        for (int j = 0; j < N; j++)
          if (j != s && elig[j] && pr[j] == best && !lrg_reg[s][j])
            win[s] = 1'b0;
      end
    end

    // Checking helpers for arbitration order.
    always_comb begin
      beaten = 1'b0;
      tie_lost = 1'b0;
      for (int s = 0; s < N; s++)
        for (int j = 0; j < N; j++) begin
          if (win[s] && elig[j] && pr[j] > pr[s]) beaten = 1'b1;
          if (win[s] && j != s && elig[j] && pr[j] == pr[s]
              && lrg_reg[j][s]) tie_lost = 1'b1;
        end
    end

    // Granted interface becomes the most recently granted.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int i = 0; i < N; i++)
          for (int j = 0; j < N; j++)
            lrg_reg[i][j] <= (i < j);
      end else begin
        for (int i = 0; i < N; i++)
          if (hs[c][i]) begin
            lrg_reg[i] <= '0;
            for (int j = 0; j < N; j++)
              if (j != i) lrg_reg[j][i] <= 1'b1;
          end
      end
    end

    // Holding register toward the master interface.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mo_reg <= '0;
      end else if (load) begin
        mo_reg.valid <= |win;
        for (int s = 0; s < N; s++)
          if (win[s]) begin
            mo_reg.qos <= eff_qos[c][s];
            mo_reg.arb <= pr[s];
            mo_reg.src <= qpr_pkg::SRC_W'(s);
          end
      end
    end

    AST_MAX_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      !beaten)
      else $error("A lower priority request was granted.");
    AST_LRG_TIE: assert property (@(posedge pclk) disable iff (!presetn)
      !tie_lost)
      else $error("Tie not granted to the least recent interface.");
  end
endmodule // qpr_regulator
`default_nettype wire

// ### bench/qpr_sink.sv
`default_nettype none
// Downstream sink that accepts master-side requests and returns completions.
module qpr_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic ret_en,
  input wire qpr_pkg::qpr_mreq_type m_ar,
  output logic m_ar_ready,
  input wire qpr_pkg::qpr_mreq_type m_aw,
  output logic m_aw_ready,
  output qpr_pkg::qpr_done_type [qpr_pkg::NUM_SI-1:0] done,
  output logic rq_pop
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tick_reg;
  // In slow mode each channel accepts only on alternate cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_reg <= 1'b0;
    else tick_reg <= ~tick_reg;
  end
  assign m_ar_ready = !slow || tick_reg;
  assign m_aw_ready = !slow || !tick_reg;
  // With ret_en set, a completion follows each acceptance; the sink sees only the final QoS.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= '0;
      rq_pop <= 1'b0;
    end else begin
      done <= '0;
      rq_pop <= m_ar.valid && m_ar_ready;
      if (ret_en && m_ar.valid && m_ar_ready) begin
        done[m_ar.src].rd <= 1'b1;
        done[m_ar.src].rd_zero <= m_ar.qos == 4'h0;
      end
      if (ret_en && m_aw.valid && m_aw_ready) begin
        done[m_aw.src].wr <= 1'b1;
        done[m_aw.src].wr_zero <= m_aw.qos == 4'h0;
      end
    end
  end
endmodule // qpr_sink
`default_nettype wire

// ### bench/qpr_regulator_bench.sv
`default_nettype none
module qpr_regulator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic m_ar_ready, m_aw_ready, rq_pop, slow, ret_en, seen, ch, dl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] qre, ar_ready, aw_ready;
  logic [4:0][3:0] prom;
  logic [3:0] q, v, a, b;
  qpr_pkg::qpr_req_type [4:0] ar_req, aw_req;
  qpr_pkg::qpr_done_type [4:0] done;
  qpr_pkg::qpr_mreq_type m_ar, m_aw, got;
  integer seed = 32'hfb477b1e;
  int fails = 0, samples_checked = 0, hs, s, least_recent_grant_order;
  qpr_regulator u_qpr_regulator (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .qos_replace_enable_inputs(qre), .ar_req(ar_req),
    .read_arb_priority_promote(prom), .ar_ready(ar_ready),
    .aw_req(aw_req), .aw_ready(aw_ready), .done(done), .m_ar(m_ar),
    .m_ar_ready(m_ar_ready), .m_aw(m_aw), .m_aw_ready(m_aw_ready),
    .rq_pop(rq_pop));
  qpr_sink u_qpr_sink (.pclk(pclk), .presetn(presetn), .slow(slow),
    .ret_en(ret_en), .m_ar(m_ar), .m_ar_ready(m_ar_ready), .m_aw(m_aw),
    .m_aw_ready(m_aw_ready), .done(done), .rq_pop(rq_pop));
  // Free-running clock at 100 MHz.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Record the latest master-side transfer, a write over a read in the same cycle, and count read handshakes on port 2.
  always @(posedge pclk) begin
    if (m_ar.valid && m_ar_ready) got <= m_ar;
    if (m_aw.valid && m_aw_ready) got <= m_aw;
    if ((m_ar.valid && m_ar_ready) || (m_aw.valid && m_aw_ready)) seen <= 1;
    if (ar_req[2].valid && ar_ready[2]) hs++;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [3:0] eff(logic [3:0] qi, bit d, bit en,
                                     logic [3:0] vo);
    return (qi != 4'h0 || d || !en) ? qi : vo;
  endfunction
  function automatic logic [11:0] addr(int si, bit c, int idx);
    return 12'(si * 64 + c * 32 + idx * 4);
  endfunction
  task automatic rst();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(bit w, logic [11:0] ad, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n++ < 50) @(posedge pclk);
    if (pready !== 1'b1) chk("pready", 1, 0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One address request, held until its handshake, then its master copy.
  task automatic send(bit wr, int si, logic [3:0] qs, bit d, logic [3:0] p);
    int n = 0;
    @(posedge pclk);
    seen = 0;
    if (wr) aw_req[si] <= {1'b1, d, qs};
    else ar_req[si] <= {1'b1, d, qs};
    prom[si] <= p;
    do @(posedge pclk);
    while (!(wr ? aw_ready[si] : ar_ready[si]) && n++ < 50);
    ar_req[si] <= '0;
    aw_req[si] <= '0;
    while (!seen && n++ < 80) @(posedge pclk);
    if (n >= 80) chk("handshake", 1, 0);
  endtask
  task automatic hold2(int cyc, logic [3:0] qs);
    hs = 0;
    @(posedge pclk);
    ar_req[2] <= {1'b1, 1'b0, qs};
    repeat (cyc) @(posedge pclk);
    ar_req[2] <= '0;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, qre, prom} = '0;
    {ar_req, aw_req, slow, ret_en, presetn, seen} = '0;
    rst();
    apb(0, addr(0, 0, 1), 0);
    chk("qos reset", 32'h0000_0000, rd);
    apb(1, addr(0, 0, 1), 32'hFFFF_FFFF);
    apb(0, addr(0, 0, 1), 0);
    chk("qos mask", qpr_pkg::MASK_QOS, rd);
    apb(0, 12'h140, 0);
    chk("unmapped", 1, err);
    $display("test registers done");
    rst();
    for (int i = 0; i < 24; i++) begin
      s = $unsigned($random(seed)) % 5;
      ch = $random(seed);
      q = ($random(seed) & 1) ? 4'h0 : 4'($random(seed));
      dl = $random(seed);
      v = 4'($random(seed));
      qre <= 5'($random(seed));
      slow <= $random(seed);
      apb(1, addr(s, ch, 0), {31'h0, i[0]});
      apb(1, addr(s, ch, 1), {28'h0, v});
      send(ch, s, q, dl, 4'($random(seed)));
      chk("qos", eff(q, dl, qre[s], i[0] ? 4'h0 : v), got.qos);
      chk("src", s, got.src);
    end
    $display("test override done");
    rst();
    slow <= 1'b0;
    least_recent_grant_order = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      a = 4'($random(seed));
      b = (i < 4) ? a : 4'($random(seed));
      ar_req[0] <= {1'b1, 1'b0, 4'h0};
      ar_req[1] <= {1'b1, 1'b0, 4'h0};
      prom[0] <= a;
      prom[1] <= b;
      @(negedge pclk);
      s = (a > b || (a == b && least_recent_grant_order == 0)) ? 0 : 1;
      chk("grant", 5'(1 << s), ar_ready);
      least_recent_grant_order = 1 - s;
      @(posedge pclk);
      ar_req[0] <= '0;
      ar_req[1] <= '0;
    end
    $display("test arbitration done");
    for (int f = 0; f < 2; f++) begin
      rst();
      apb(1, addr(2, 0, 0), 32'h0000_0008);
      apb(1, addr(2, 0, 4), f ? 32'h0000_8001 : 32'h0000_0001);
      hold2(30, 4'h0);
      chk("ot bound", 1, hs <= 1 + f && hs > 0);
      hold2(10, 4'h5);
      chk("uncounted", 1, hs > 2);
    end
    $display("test outstanding done");
    // Idle-rise regulation climbs to the maximum, then normal mode holds it.
    rst();
    qre <= 5'h1F;
    apb(1, addr(0, 0, 1), 32'h0000_F000);
    apb(1, addr(0, 0, 3), 32'h0000_0080);
    apb(1, addr(0, 0, 0), 32'h0000_0007);
    repeat (600) @(posedge pclk);
    apb(0, addr(0, 0, 5), 0);
    chk("idle rise", 32'h0000_000F, rd);
    apb(1, addr(0, 0, 0), 32'h0000_0003);
    repeat (50) @(posedge pclk);
    apb(0, addr(0, 0, 5), 0);
    chk("idle hold", 32'h0000_000F, rd);
    send(0, 0, 4'h0, 1'b0, 4'h3);
    chk("regulated", 4'hF, got.qos);
    $display("test regulation done");
    print_verdict();
  end
endmodule // qpr_regulator_bench
`default_nettype wire
